// file: spwm_pkg.sv
/*
  Package for the sine PWM H-bridge controller: timing constants, duty limits,
  mode states and the packed drive carrier.
  Assumes a 10 MHz system clock and synchronous active-high reset.
*/
package spwm_pkg;

  // ----------------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned CARRIER_HZ      = 20_000;
  localparam int unsigned CARRIER_CYC     = CLK_HZ / CARRIER_HZ;
  localparam int unsigned DEAD_NS         = 500;
  localparam int unsigned DEAD_CYC        = (DEAD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned OFF_WAIT_US     = 100;
  localparam int unsigned OFF_WAIT_CYC    = OFF_WAIT_US * (CLK_HZ / 1_000_000);
  localparam int unsigned RELAY_SETTLE_US = 400;
  localparam int unsigned RELAY_CYC       = RELAY_SETTLE_US * (CLK_HZ / 1_000_000);

  // ----------------------------------------------------------------------------
  // Duty limits in 1/256 units, output scale factors in 1/64 units
  // ----------------------------------------------------------------------------
  localparam logic [7:0] DUTY_MIN_NL   = 8'h1a;
  localparam logic [7:0] DUTY_MAX_NL   = 8'he1;
  localparam logic [7:0] DUTY_CAP      = 8'hf0;
  localparam logic [7:0] CHG_DUTY_INIT = 8'h14;
  localparam logic [7:0] CHG_DUTY_MAX  = 8'h80;
  localparam logic [7:0] SCALE_UNITY   = 8'h40;
  localparam logic [7:0] SCALE_MAX     = 8'h5f;
  localparam logic [9:0] RESET_ZERO10  = 10'h000;
  localparam int unsigned SINE_DEPTH   = 256;

  // ----------------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_OFF    = 3'b000,
    ST_INV    = 3'b001,
    ST_STOP   = 3'b011,
    ST_RELAY  = 3'b010,
    ST_CHARGE = 3'b110
  } spwm_mode_type;

  typedef struct packed {
    logic hi_a;
    logic lo_a;
    logic hi_b;
    logic lo_b;
  } spwm_drive_type;

endpackage

// file: spwm_sine_rom.sv
/*
  Sine lookup memory: a full-wave table generated at elaboration, read data
  registered.
  Assumes the caller presents the address one cycle before it needs the data.
*/
module spwm_sine_rom
  import spwm_pkg::*;
#(
  parameter int DEPTH = SINE_DEPTH
) (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_addr,
  output logic      [7:0] o_data
);

  // ----------------------------------------------------------------------------
  // Table of 128 + 127*sin(2*pi*k/256), built at elaboration.
  // ----------------------------------------------------------------------------
  logic [7:0] table_mem [DEPTH];

  genvar g;
  generate
    for (g = 0; g < DEPTH; g++) begin : g_tab
      localparam real ANG = 6.283185307 * g / DEPTH;
      localparam real A2  = (ANG > 3.141592654) ? ANG - 6.283185307 : ANG;
      localparam real S2  = A2 - A2**3/6.0 + A2**5/120.0 - A2**7/5040.0 + A2**9/362880.0;
      localparam int  V   = int'(128.0 + 127.0 * S2);
      assign table_mem[g] = V[7:0];
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    o_data <= table_mem[i_addr];
  end

endmodule // spwm_sine_rom

// file: spwm_ctrl.sv
/*
  Sine PWM H-bridge controller: inverter mode with unipolar sine PWM on both
  legs, mains mode with bypass relay and low-side charge PWM, trip handling,
  output-voltage duty scaling and a small register port with interrupts.
  Assumes synchronous comparator and sense inputs and a register master that
  never issues read and write strobes together.
*/
// Our own choices: the address-and-strobe port and the address map.
module spwm_ctrl
  import spwm_pkg::*;
#(
  parameter int PERIOD = CARRIER_CYC,
  parameter int DEAD   = DEAD_CYC
) (
  input  wire logic       i_clk,
  input  wire logic       i_sys_rst,
  input  wire logic       i_ac_valid,
  input  wire logic       i_over_discharge_trip,
  input  wire logic       i_over_charge_trip,
  input  wire logic       i_charge_low,
  input  wire logic       i_charge_high,
  input  wire logic       i_vout_low,
  input  wire logic       i_vout_high,
  input  wire logic [3:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  output logic            o_leg_a_primary_pwm,
  output logic            o_leg_a_complement_pwm,
  output logic            o_leg_b_primary_pwm,
  output logic            o_leg_b_complement_pwm,
  output logic            o_relay,
  output logic            o_irq
);

  // ----------------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------------
  localparam logic [3:0] A_CTRL   = 4'h0;
  localparam logic [3:0] A_STATUS = 4'h1;
  localparam logic [3:0] A_MASK   = 4'h2;
  localparam logic [3:0] A_MODE   = 4'h3;
  localparam logic [3:0] A_DUTY   = 4'h4;
  localparam logic [3:0] A_SCALE  = 4'h5;

  // ----------------------------------------------------------------------------
  // Carrier counter and period boundary
  // ----------------------------------------------------------------------------
  logic [9:0] cnt_ff;
  logic [7:0] phase_ff;
  wire        boundary = (cnt_ff == 10'(PERIOD - 1));

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_ff   <= RESET_ZERO10;
      phase_ff <= 8'h00;
    end else begin
      cnt_ff   <= boundary ? RESET_ZERO10 : cnt_ff + 10'h001;
      phase_ff <= boundary ? phase_ff + 8'h01 : phase_ff;
    end
  end

  // ----------------------------------------------------------------------------
  // Sine reference for both legs
  // ----------------------------------------------------------------------------
  logic [7:0] sine_a;
  logic [7:0] sine_b;

  spwm_sine_rom u_rom_a (
    .i_clk  (i_clk),
    .i_addr (phase_ff),
    .o_data (sine_a)
  );

  spwm_sine_rom u_rom_b (
    .i_clk  (i_clk),
    .i_addr (phase_ff + 8'h80),
    .o_data (sine_b)
  );

  // ----------------------------------------------------------------------------
  // Duty computation
  // ----------------------------------------------------------------------------
  function automatic logic [7:0] map_duty(input logic [7:0] s, input logic [7:0] k);
    logic [15:0] base;
    logic [15:0] scaled;
    base   = 16'(DUTY_MIN_NL) + ((16'(s) * 16'(DUTY_MAX_NL - DUTY_MIN_NL)) >> 8);
    scaled = (base * 16'(k)) >> 6;
    map_duty = (scaled > 16'(DUTY_CAP)) ? DUTY_CAP : scaled[7:0];
  endfunction

  logic [7:0] scale_ff;
  logic [7:0] chg_duty_ff;
  logic [7:0] duty_a_ff;
  logic [7:0] duty_b_ff;
  spwm_mode_type mode_ff;
  wire [7:0]  nxt_duty_a = map_duty(sine_a, scale_ff);
  wire [7:0]  nxt_duty_b = map_duty(sine_b, scale_ff);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      duty_a_ff <= 8'h00;
      duty_b_ff <= 8'h00;
    end else if (boundary) begin
      // The relay wait preloads the initial charge duty, so charging never starts on a sine duty.
      duty_a_ff <= (mode_ff == ST_CHARGE || mode_ff == ST_RELAY) ? chg_duty_ff : nxt_duty_a;
      duty_b_ff <= (mode_ff == ST_CHARGE || mode_ff == ST_RELAY) ? chg_duty_ff : nxt_duty_b;
    end
  end

  // Output voltage regulation, one step per carrier period.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      scale_ff <= SCALE_UNITY;
    end else if (boundary && mode_ff == ST_INV) begin
      if (i_vout_low && scale_ff < SCALE_MAX) begin
        scale_ff <= scale_ff + 8'h01;
      end else if (i_vout_high && scale_ff > SCALE_UNITY) begin
        scale_ff <= scale_ff - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------------------
  logic [12:0] wait_ff;
  logic        tripped_ff;
  logic        enable_ff;
  logic        rearm;
  spwm_mode_type nxt_mode;
  wire         trip_in = i_over_discharge_trip | i_over_charge_trip;
  wire         wait_done = (wait_ff == 13'h0000);

  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      ST_OFF: begin
        if (enable_ff && !tripped_ff) begin
          nxt_mode = i_ac_valid ? ST_STOP : ST_INV;
        end
      end
      ST_INV: begin
        if (i_ac_valid) begin
          nxt_mode = ST_STOP;
        end
      end
      ST_STOP: begin
        if (!i_ac_valid) begin
          nxt_mode = ST_INV;
        end else if (wait_done) begin
          nxt_mode = ST_RELAY;
        end
      end
      ST_RELAY: begin
        if (!i_ac_valid) begin
          nxt_mode = ST_STOP;
        end else if (wait_done) begin
          nxt_mode = ST_CHARGE;
        end
      end
      ST_CHARGE: begin
        if (!i_ac_valid) begin
          nxt_mode = ST_STOP;
        end
      end
      default: nxt_mode = ST_OFF;
    endcase
    if (tripped_ff || !enable_ff) begin
      nxt_mode = ST_OFF;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mode_ff <= ST_OFF;
      wait_ff <= 13'h0000;
    end else begin
      mode_ff <= nxt_mode;
      if (nxt_mode != mode_ff) begin
        wait_ff <= (nxt_mode == ST_STOP) ? 13'(OFF_WAIT_CYC) : 13'(RELAY_CYC);
      end else if (!wait_done) begin
        wait_ff <= wait_ff - 13'h0001;
      end
    end
  end

  // Trip latch: set wins over software re-arm.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      tripped_ff <= 1'b0;
    end else if (trip_in) begin
      tripped_ff <= 1'b1;
    end else if (rearm) begin
      tripped_ff <= 1'b0;
    end
  end

  // Charge current loop.
  always_ff @(posedge i_clk) begin
    if (i_sys_rst || mode_ff != ST_CHARGE) begin
      chg_duty_ff <= CHG_DUTY_INIT;
    end else if (boundary) begin
      if (i_charge_low && chg_duty_ff < CHG_DUTY_MAX) begin
        chg_duty_ff <= chg_duty_ff + 8'h01;
      end else if (i_charge_high && chg_duty_ff > 8'h01) begin
        chg_duty_ff <= chg_duty_ff - 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Compare, dead band and output gating
  // ----------------------------------------------------------------------------
  wire [9:0] thr_a = 10'((32'(duty_a_ff) * PERIOD) >> 8);
  wire [9:0] thr_b = 10'((32'(duty_b_ff) * PERIOD) >> 8);
  wire       raw_a = (cnt_ff < thr_a);
  wire       raw_b = (cnt_ff < thr_b);
  wire       run   = !tripped_ff && !trip_in && (mode_ff == ST_INV || mode_ff == ST_CHARGE);

  spwm_drive_type drv_ff;
  logic [7:0] db_ff [4];
  logic [3:0] want;

  assign want[3] = run && mode_ff == ST_INV && raw_a;
  assign want[2] = run && (mode_ff == ST_INV ? !raw_a : raw_a);
  assign want[1] = run && mode_ff == ST_INV && raw_b;
  assign want[0] = run && (mode_ff == ST_INV ? !raw_b : raw_a);

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_db
      localparam int PEER = gi ^ 1;
      // Each switch turns on only after its leg partner request held low for DEAD cycles.
      always_ff @(posedge i_clk) begin
        if (i_sys_rst || want[PEER] || !run) begin
          db_ff[gi] <= 8'h00;
        end else if (db_ff[gi] != 8'(DEAD)) begin
          db_ff[gi] <= db_ff[gi] + 8'h01;
        end
      end
    end
  endgenerate

  always_ff @(posedge i_clk) begin
    if (i_sys_rst || trip_in) begin
      drv_ff <= '0;
    end else begin
      drv_ff.hi_a <= want[3] && db_ff[3] == 8'(DEAD);
      drv_ff.lo_a <= want[2] && db_ff[2] == 8'(DEAD);
      drv_ff.hi_b <= want[1] && db_ff[1] == 8'(DEAD);
      drv_ff.lo_b <= want[0] && db_ff[0] == 8'(DEAD);
    end
  end

  assign o_leg_a_primary_pwm    = drv_ff.hi_a;
  assign o_leg_a_complement_pwm = drv_ff.lo_a;
  assign o_leg_b_primary_pwm    = drv_ff.hi_b;
  assign o_leg_b_complement_pwm = drv_ff.lo_b;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_relay <= 1'b0;
    end else begin
      o_relay <= (nxt_mode == ST_RELAY || nxt_mode == ST_CHARGE);
    end
  end

  // ----------------------------------------------------------------------------
  // Register port and interrupts
  // ----------------------------------------------------------------------------
  logic [2:0] status_ff;
  logic [2:0] mask_ff;
  wire  [2:0] events = {trip_in & ~tripped_ff,
                        mode_ff != ST_CHARGE && nxt_mode == ST_CHARGE,
                        mode_ff != ST_INV && nxt_mode == ST_INV};
  wire        rd_status = i_rd && i_addr == A_STATUS;

  assign rearm = i_wr && i_addr == A_CTRL && i_wdata[1];

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      enable_ff <= 1'b0;
      mask_ff   <= 3'h0;
      status_ff <= 3'h0;
      o_rdata   <= 8'h00;
    end else begin
      if (i_wr && i_addr == A_CTRL) begin
        enable_ff <= i_wdata[0];
      end
      if (i_wr && i_addr == A_MASK) begin
        mask_ff <= i_wdata[2:0];
      end
      status_ff <= events | (rd_status ? 3'h0 : status_ff);
      case (i_addr)
        A_CTRL:   o_rdata <= {6'h00, tripped_ff, enable_ff};
        A_STATUS: o_rdata <= {5'h00, status_ff};
        A_MASK:   o_rdata <= {5'h00, mask_ff};
        A_MODE:   o_rdata <= {4'h0, o_relay, mode_ff};
        A_DUTY:   o_rdata <= (mode_ff == ST_CHARGE) ? chg_duty_ff : duty_a_ff;
        A_SCALE:  o_rdata <= scale_ff;
        default:  o_rdata <= 8'h00;
      endcase
    end
  end

  assign o_irq = |(status_ff & mask_ff);

  // ----------------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------------
  sequence trip_seen;
    trip_in;
  endsequence

  sequence drives_dark;
    (drv_ff == '0) [*2];
  endsequence

  trip_off_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) trip_seen |=> drives_dark)
    else $error("Drives active after trip");
  leg_a_db_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) !(drv_ff.hi_a && drv_ff.lo_a))
    else $error("Leg A shoot-through");
  leg_b_db_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) !(drv_ff.hi_b && drv_ff.lo_b))
    else $error("Leg B shoot-through");
  chg_hi_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    mode_ff == ST_CHARGE [*2] |-> !drv_ff.hi_a && !drv_ff.hi_b && drv_ff.lo_a == drv_ff.lo_b)
    else $error("High side on while charging");
  relay_seq_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(o_relay) |-> $past(drv_ff) == '0)
    else $error("Relay closed with drives on");
  relay_inv_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    mode_ff == ST_INV |=> !o_relay)
    else $error("Relay closed in inverter mode");
  duty_cap_a: assert property (@(posedge i_clk) disable iff (i_sys_rst) duty_a_ff <= DUTY_CAP)
    else $error("Duty above cap");
  duty_upd_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !$past(boundary) |-> $stable(duty_a_ff))
    else $error("Duty changed mid period");
  off_dark_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    mode_ff == ST_OFF [*2] |-> drv_ff == '0)
    else $error("Drives active while off");
  chg_init_a: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $rose(mode_ff == ST_CHARGE) |-> chg_duty_ff == CHG_DUTY_INIT)
    else $error("Charge duty not initial");

endmodule // spwm_ctrl

// file: spwm_bridge_model.sv
/*
  Behavioural model of the gate driver and full-bridge power stage: it turns
  the four gate drives into the two bridge node levels and counts cycles in
  which both switches of one leg conduct.
  Assumes drives are registered on the rising edge of the shared clock.
*/
module spwm_bridge_model
  import spwm_pkg::*;
(
  input  wire logic            i_clk,
  input  wire spwm_drive_type  i_drive,
  output logic                 o_bridge_out_pos,
  output logic                 o_bridge_out_neg,
  output int                   o_shoot_count
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_bridge_out_pos = 1'b0;
    o_bridge_out_neg = 1'b1;
    o_shoot_count    = 0;
  end

  // A floating node shows the inverse of its last level, never a held value.
  always @(posedge i_clk) begin
    if ((i_drive.hi_a && i_drive.lo_a) || (i_drive.hi_b && i_drive.lo_b)) begin
      o_shoot_count <= o_shoot_count + 1;
    end
    o_bridge_out_pos <= i_drive.hi_a ? 1'b1 : (i_drive.lo_a ? 1'b0 : !o_bridge_out_pos);
    o_bridge_out_neg <= i_drive.hi_b ? 1'b1 : (i_drive.lo_b ? 1'b0 : !o_bridge_out_neg);
  end
endmodule  // spwm_bridge_model

// file: spwm_ctrl_test.sv
/*
  Self-checking testbench of the sine PWM H-bridge controller.
  Assumes the package, the controller and the bridge model are compiled first.
*/
module spwm_ctrl_test
  import spwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PER = 100;
  localparam int DB  = 5;
  logic           clk, rst, ac_valid, odt, oct, chg_low, chg_high, vlow, vhigh, wr, rd;
  logic [3:0]     addr;
  logic [7:0]     wdata, rdata, rv, d0;
  logic           ap, ac, bp, bc, relay, irq, bpos, bneg, ap_q, bp_q, lo_q;
  spwm_drive_type drv;
  int             shoots, mismatches, checks, ap_edges, bp_edges, lo_edges;
  int             on_a, lo_diff, hi_on, drv_on, relay_on;

  assign drv = {ap, ac, bp, bc};

  spwm_ctrl #(.PERIOD(PER), .DEAD(DB)) spwm_ctrl_i (.i_clk(clk), .i_sys_rst(rst), .i_ac_valid(ac_valid),
    .i_over_discharge_trip(odt), .i_over_charge_trip(oct), .i_charge_low(chg_low), .i_charge_high(chg_high),
    .i_vout_low(vlow), .i_vout_high(vhigh), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_leg_a_primary_pwm(ap), .o_leg_a_complement_pwm(ac), .o_leg_b_primary_pwm(bp),
    .o_leg_b_complement_pwm(bc), .o_relay(relay), .o_irq(irq));
  spwm_bridge_model spwm_bridge_model_i (.i_clk(clk), .i_drive(drv), .o_bridge_out_pos(bpos),
    .o_bridge_out_neg(bneg), .o_shoot_count(shoots));

  // ----------------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------------
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic rd_reg(input logic [3:0] a);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 rv = rdata;
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Gathers edge and on-time counts of the drives over n cycles.
  task automatic measure(input int n);
    {ap_edges, bp_edges, lo_edges, on_a, lo_diff, hi_on, drv_on, relay_on} = '0;
    ap_q = ap;
    bp_q = bp;
    lo_q = ac;
    repeat (n) begin
      @(posedge clk);
      #1;
      if (ap && !ap_q) ap_edges++;
      if (bp && !bp_q) bp_edges++;
      if (ac && !lo_q) lo_edges++;
      on_a     += int'(ap) + int'(ac);
      lo_diff  += int'(ac != bc);
      hi_on    += int'(ap | bp);
      drv_on   += int'(drv != '0);
      relay_on += int'(relay);
      ap_q = ap;
      bp_q = bp;
      lo_q = ac;
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset();
    measure(3 * PER);
    check("rst_drv", 16'(drv_on + relay_on + int'(irq)), 16'h0);
    rd_reg(4'h5);
    check("rst_scale", 16'(rv), 16'(SCALE_UNITY));
    rd_reg(4'h3);
    check("rst_mode", 16'(rv), 16'(ST_OFF));
    wr_reg(4'hf, 8'h55);
    rd_reg(4'h5);
    check("unmapped_wr", 16'(rv), 16'(SCALE_UNITY));
    rd_reg(4'hf);
    check("unmapped_rd", 16'(rv), 16'h0);
    wr_reg(4'h2, 8'h07);
    rd_reg(4'h2);
    check("mask_rb", 16'(rv), 16'h7);
  endtask

  task automatic t_inverter();
    wr_reg(4'h0, 8'h01);
    measure(20);
    check("inv_irq", 16'(irq), 16'h1);
    rd_reg(4'h1);
    check("inv_status", 16'(rv), 16'h1);
    check("irq_clear", 16'(irq), 16'h0);
    rd_reg(4'h3);
    check("inv_mode", 16'(rv), 16'(ST_INV));
    measure(10 * PER);
    check("a_edges", 16'(ap_edges), 16'd10);
    check("b_edges", 16'(bp_edges), 16'd10);
    check("shoot", 16'(shoots), 16'h0);
    check("a_on", 16'(on_a >= 10 * (PER - 2 * DB) - 2 * DB && on_a <= 10 * (PER - 2 * DB) + 2 * DB), 16'h1);
    check("inv_relay", 16'(relay_on), 16'h0);
    repeat (8) begin
      measure(4 * PER);
      rd_reg(4'h4);
      check("duty_nl", 16'(rv >= DUTY_MIN_NL && rv <= DUTY_MAX_NL), 16'h1);
    end
  endtask

  task automatic t_scale();
    @(posedge clk) vlow <= 1'b1;
    measure(64 * PER);
    rd_reg(4'h5);
    check("scale_up", 16'(rv), 16'(SCALE_MAX));
    repeat (4) begin
      measure(3 * PER);
      rd_reg(4'h4);
      check("duty_cap", 16'(rv <= DUTY_CAP), 16'h1);
    end
    @(posedge clk);
    vlow  <= 1'b0;
    vhigh <= 1'b1;
    measure(64 * PER);
    rd_reg(4'h5);
    check("scale_down", 16'(rv), 16'(SCALE_UNITY));
    @(posedge clk) vhigh <= 1'b0;
  endtask

  task automatic t_trip();
    for (int k = 0; k < 2; k++) begin
      wr_reg(4'h2, (k == 0) ? 8'h07 : 8'h00);
      @(posedge clk);
      if (k == 0) odt <= 1'b1;
      else oct <= 1'b1;
      @(posedge clk);
      @(posedge clk);
      #1;
      check("trip_drv", 16'(drv), 16'h0);
      check("trip_irq", 16'(irq), 16'(k == 0));
      @(posedge clk);
      odt <= 1'b0;
      oct <= 1'b0;
      measure(3 * PER);
      check("trip_hold", 16'(drv_on), 16'h0);
      rd_reg(4'h1);
      check("trip_status", 16'(rv), 16'h4);
      rd_reg(4'h3);
      check("trip_mode", 16'(rv), 16'(ST_OFF));
      wr_reg(4'h0, 8'h03);
      measure(3 * PER);
      check("rearm_run", 16'(ap_edges >= 2), 16'h1);
      rd_reg(4'h1);
      check("rearm_status", 16'(rv), 16'h1);
    end
    wr_reg(4'h2, 8'h07);
  endtask

  task automatic t_mains();
    @(posedge clk) ac_valid <= 1'b1;
    // Drives launched in the last inverter cycle still stand for one cycle.
    @(posedge clk);
    measure(OFF_WAIT_CYC - 50);
    check("stop_off", 16'(drv_on + relay_on), 16'h0);
    measure(100);
    check("relay_on", 16'(relay), 16'h1);
    rd_reg(4'h3);
    check("relay_mode", 16'(rv), 16'({1'b1, ST_RELAY}));
    measure(RELAY_CYC - 200);
    check("relay_off", 16'(drv_on), 16'h0);
    measure(300);
    rd_reg(4'h3);
    check("chg_mode", 16'(rv), 16'({1'b1, ST_CHARGE}));
    rd_reg(4'h4);
    check("chg_init", 16'(rv), 16'(CHG_DUTY_INIT));
    rd_reg(4'h1);
    check("chg_status", 16'(rv), 16'h2);
    measure(5 * PER);
    check("chg_hi", 16'(hi_on + lo_diff), 16'h0);
    check("chg_edges", 16'(lo_edges), 16'd5);
    check("chg_on", 16'(on_a >= 35 && on_a <= 43), 16'h1);
    check("chg_relay", 16'(relay_on), 16'(5 * PER));
    @(posedge clk) chg_low <= 1'b1;
    measure(10 * PER);
    @(posedge clk) chg_low <= 1'b0;
    rd_reg(4'h4);
    check("chg_raise", 16'(rv >= CHG_DUTY_INIT + 9 && rv <= CHG_DUTY_INIT + 11), 16'h1);
    d0 = rv;
    @(posedge clk) chg_high <= 1'b1;
    measure(4 * PER);
    @(posedge clk) chg_high <= 1'b0;
    rd_reg(4'h4);
    check("chg_lower", 16'(rv >= d0 - 8'h05 && rv <= d0 - 8'h03), 16'h1);
    @(posedge clk) chg_low <= 1'b1;
    measure(120 * PER);
    @(posedge clk) chg_low <= 1'b0;
    rd_reg(4'h4);
    check("chg_max", 16'(rv), 16'(CHG_DUTY_MAX));
    @(posedge clk) ac_valid <= 1'b0;
    measure(2 * PER);
    check("mains_gone", 16'(relay), 16'h0);
    rd_reg(4'h3);
    check("back_inv", 16'(rv), 16'(ST_INV));
  endtask

  // ----------------------------------------------------------------------------
  // Clock, sequence and watchdog
  // ----------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    {rst, ac_valid, odt, oct, chg_low, chg_high, vlow, vhigh, wr, rd} = 10'h200;
    {addr, wdata} = 12'h000;
    {mismatches, checks} = '0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_inverter();
    t_scale();
    t_trip();
    t_mains();
    conclude();
  end

  // The full sequence takes about 40000 cycles.
  initial begin
    #8_000_000;
    mismatches++;
    conclude();
  end
endmodule  // spwm_ctrl_test
